// *** design/tla_status_alarm.v ***
// Limit comparison, sticky status, interrupt latch and overtemperature
// outputs of a three-channel temperature monitor.
// Assumes a serial bus front end on the same clock that issues one-cycle
// register read and write strobes, and an ADC that reports results.
`include "tla_consts.vh"
`timescale 1ns/1ps
module tla_status_alarm
#(
  parameter [30:0] P_SLOW_CYCLES = `TLA_SLOW_PERIOD_MS * (`TLA_CLK_KHZ)
)
(
  // Clock, reset, enable
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_clk_en,
  // Register access from the bus front end
  input  wire [7:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_rd,
  output reg  [7:0]  o_reg_rdata,
  input  wire        i_ara_read,
  // ADC results, channel 0 local, 1 remote A, 2 remote B
  input  wire        i_adc_busy,
  input  wire        i_meas_valid,
  input  wire [1:0]  i_meas_chan,
  input  wire [10:0] i_meas_value,
  // Open-sensor detector pins
  input  wire        i_remote_a_open,
  input  wire        i_remote_b_open,
  // ADC control
  output reg         o_conv_start,
  output wire [3:0]  o_conv_rate,
  output wire        o_standby_select,
  // Alarm pins
  output reg         o_critical_overtemp_n,
  output reg         o_shared_pin_n
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration and limit registers

  reg  [7:0]  cfg_r;
  reg  [3:0]  rate_r;
  reg  [7:0]  hyst_r;
  reg  [7:0]  loc_high_r;
  reg  [7:0]  loc_low_r;
  reg  [7:0]  loc_crit_r;
  reg  [7:0]  rem_high_hb_r [0:1];
  reg  [2:0]  rem_high_lb_r [0:1];
  reg  [7:0]  rem_low_hb_r  [0:1];
  reg  [2:0]  rem_low_lb_r  [0:1];
  reg  [7:0]  rem_crit_r    [0:1];
  reg  [7:0]  loc_meas_r;
  reg  [10:0] rema_meas_r;
  reg  [10:0] remb_meas_r;
  reg         alert_latch_r;
  reg  [30:0] rate_cnt_r;

  wire        rsel;
  wire        wr_cfg;
  wire        rd_stat1;
  wire        rd_stat2;
  wire [1:0]  open_sync;
  wire        shared_is_hot;
  wire        alert_out;

  assign rsel = cfg_r[`TLA_CFG_REM_SEL];
  assign wr_cfg = i_reg_wr && (i_reg_addr == `TLA_WR_CFG1);
  assign rd_stat1 = i_reg_rd && (i_reg_addr == `TLA_RD_STAT1);
  assign rd_stat2 = i_reg_rd && (i_reg_addr == `TLA_RD_STAT2);
  assign o_conv_rate = rate_r;
  assign o_standby_select = cfg_r[`TLA_CFG_STANDBY];
  assign shared_is_hot = cfg_r[`TLA_CFG_PIN_SEL];

  integer k;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cfg_r      <= `TLA_RST_CFG1;
      rate_r     <= `TLA_RST_RATE;
      hyst_r     <= `TLA_RST_HYST;
      loc_high_r <= `TLA_RST_HIGH;
      loc_low_r  <= `TLA_RST_LOW;
      loc_crit_r <= `TLA_RST_CRIT;
      for (k = 0; k < 2; k = k + 1)
      begin
        rem_high_hb_r[k] <= `TLA_RST_HIGH;
        rem_high_lb_r[k] <= `TLA_RST_LB;
        rem_low_hb_r[k]  <= `TLA_RST_LOW;
        rem_low_lb_r[k]  <= `TLA_RST_LB;
        rem_crit_r[k]    <= `TLA_RST_CRIT;
      end
    end
    else if (i_clk_en && i_reg_wr)
    begin
      // Limits take effect at once, standby or not
      case (i_reg_addr)
        `TLA_WR_CFG1:        cfg_r <= i_reg_wdata;
        `TLA_WR_RATE:        rate_r <= i_reg_wdata[3:0];
        `TLA_RW_HYST:        hyst_r <= i_reg_wdata;
        `TLA_WR_LOC_HIGH:    loc_high_r <= i_reg_wdata;
        `TLA_WR_LOC_LOW:     loc_low_r <= i_reg_wdata;
        `TLA_RW_LOC_CRIT:    loc_crit_r <= i_reg_wdata;
        `TLA_RW_REMA_CRIT:   rem_crit_r[0] <= i_reg_wdata;
        `TLA_RW_REMB_CRIT:   rem_crit_r[1] <= i_reg_wdata;
        `TLA_WR_REM_HIGH_HB: rem_high_hb_r[rsel] <= i_reg_wdata;
        `TLA_WR_REM_LOW_HB:  rem_low_hb_r[rsel] <= i_reg_wdata;
        `TLA_RW_REM_HIGH_LB: rem_high_lb_r[rsel] <= i_reg_wdata[7:5];
        `TLA_RW_REM_LOW_LB:  rem_low_lb_r[rsel] <= i_reg_wdata[7:5];
        default:             cfg_r <= cfg_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Measurement capture

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      loc_meas_r  <= 8'h00;
      rema_meas_r <= 11'h000;
      remb_meas_r <= 11'h000;
    end
    else if (i_clk_en && i_meas_valid)
    begin
      // Flags re-evaluate from the new value on the next edge
      case (i_meas_chan)
        2'h0:    loc_meas_r <= i_meas_value[10:3];
        2'h1:    rema_meas_r <= i_meas_value;
        2'h2:    remb_meas_r <= i_meas_value;
        default: loc_meas_r <= loc_meas_r;
      endcase
    end
  end

  tla_sync
  #(
    .W (2)
  )
  u_open_sync
  (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_remote_b_open, i_remote_a_open}),
    .o_sync    (open_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Channels

  wire l_hi;
  wire l_lo;
  wire l_crit;
  wire l_hot;
  wire a_hi;
  wire a_lo;
  wire a_open;
  wire a_crit;
  wire a_hot;
  wire b_hi;
  wire b_lo;
  wire b_open;
  wire b_crit;
  wire b_hot;

  tla_chan u_loc
  (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_meas      ({loc_meas_r, 3'h0}),
    .i_open      (1'b0),
    .i_high_lim  ({loc_high_r, 3'h0}),
    .i_low_lim   ({loc_low_r, 3'h0}),
    .i_crit_lim  (loc_crit_r),
    .i_hyst      (hyst_r),
    .i_rd_clr    (rd_stat1),
    .o_high_flag (l_hi),
    .o_low_flag  (l_lo),
    .o_open_flag (),
    .o_crit_flag (l_crit),
    .o_hot_flag  (l_hot)
  );

  tla_chan u_rema
  (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_meas      (rema_meas_r),
    .i_open      (open_sync[0]),
    .i_high_lim  ({rem_high_hb_r[0], rem_high_lb_r[0]}),
    .i_low_lim   ({rem_low_hb_r[0], rem_low_lb_r[0]}),
    .i_crit_lim  (rem_crit_r[0]),
    .i_hyst      (hyst_r),
    .i_rd_clr    (rd_stat1),
    .o_high_flag (a_hi),
    .o_low_flag  (a_lo),
    .o_open_flag (a_open),
    .o_crit_flag (a_crit),
    .o_hot_flag  (a_hot)
  );

  tla_chan u_remb
  (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_meas      (remb_meas_r),
    .i_open      (open_sync[1]),
    .i_high_lim  ({rem_high_hb_r[1], rem_high_lb_r[1]}),
    .i_low_lim   ({rem_low_hb_r[1], rem_low_lb_r[1]}),
    .i_crit_lim  (rem_crit_r[1]),
    .i_hyst      (hyst_r),
    .i_rd_clr    (rd_stat2),
    .o_high_flag (b_hi),
    .o_low_flag  (b_lo),
    .o_open_flag (b_open),
    .o_crit_flag (b_crit),
    .o_hot_flag  (b_hot)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status words and interrupt latch

  wire [7:0] stat1;
  wire [7:0] stat2;
  wire       alert_cond;
  wire       mask_all;

  assign mask_all = cfg_r[`TLA_CFG_MASK_ALL];
  assign alert_out = alert_latch_r & ~mask_all & ~shared_is_hot;
  assign stat1 = {i_adc_busy, l_hi, l_lo, a_hi, a_lo, a_open,
                  a_crit, l_crit};
  assign stat2 = {3'h0, b_hi, b_lo, b_open, b_crit, alert_out};

  assign alert_cond = l_hi | l_lo
                    | ((a_hi | a_lo | a_open) & ~cfg_r[`TLA_CFG_MASK_REMA])
                    | ((b_hi | b_lo | b_open) & ~cfg_r[`TLA_CFG_MASK_REMB]);

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      alert_latch_r <= 1'b0;
    else if (i_clk_en)
    begin
      // Masked conditions never reach the latch; set wins over service
      if (alert_cond && !mask_all && !shared_is_hot)
        alert_latch_r <= 1'b1;
      else if (i_ara_read)
        alert_latch_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm pins

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_critical_overtemp_n <= 1'b1;
      o_shared_pin_n        <= 1'b1;
    end
    else if (i_clk_en)
    begin
      // Driven in standby too; only the shared pin in alert mode waits for host service
      o_critical_overtemp_n <= ~(l_crit | a_crit | b_crit);
      if (shared_is_hot)
        o_shared_pin_n <= ~(l_hot | a_hot | b_hot);
      else
        o_shared_pin_n <= ~alert_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 8'h00;
    else if (i_clk_en && i_reg_rd)
    begin
      case (i_reg_addr)
        `TLA_RD_STAT1:       o_reg_rdata <= stat1;
        `TLA_RD_STAT2:       o_reg_rdata <= stat2;
        `TLA_RD_CFG1:        o_reg_rdata <= cfg_r;
        `TLA_RD_RATE:        o_reg_rdata <= {4'h0, rate_r};
        `TLA_RW_HYST:        o_reg_rdata <= hyst_r;
        `TLA_RD_LOC_HIGH:    o_reg_rdata <= loc_high_r;
        `TLA_RD_LOC_LOW:     o_reg_rdata <= loc_low_r;
        `TLA_RW_LOC_CRIT:    o_reg_rdata <= loc_crit_r;
        `TLA_RW_REMA_CRIT:   o_reg_rdata <= rem_crit_r[0];
        `TLA_RW_REMB_CRIT:   o_reg_rdata <= rem_crit_r[1];
        `TLA_RD_REM_HIGH_HB: o_reg_rdata <= rem_high_hb_r[rsel];
        `TLA_RD_REM_LOW_HB:  o_reg_rdata <= rem_low_hb_r[rsel];
        `TLA_RW_REM_HIGH_LB: o_reg_rdata <= {rem_high_lb_r[rsel], 5'h00};
        `TLA_RW_REM_LOW_LB:  o_reg_rdata <= {rem_low_lb_r[rsel], 5'h00};
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion rate timer

  wire [3:0]  rate_eff;
  wire [30:0] period;

  // Codes above the fastest run at the fastest period
  assign rate_eff = (rate_r > `TLA_RATE_MAX) ? `TLA_RATE_MAX : rate_r;
  assign period = P_SLOW_CYCLES >> rate_eff;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rate_cnt_r   <= 31'h00000000;
      o_conv_start <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_conv_start <= 1'b0;
      if (o_standby_select)
        rate_cnt_r <= 31'h00000000;
      else if (rate_cnt_r >= period - 31'h00000001)
      begin
        rate_cnt_r   <= 31'h00000000;
        o_conv_start <= 1'b1;
      end
      else
        rate_cnt_r <= rate_cnt_r + 31'h00000001;
    end
  end

  // Unused by this block beyond decode
  wire unused_cfg_wr;
  assign unused_cfg_wr = wr_cfg;

endmodule

// *** design/tla_consts.vh ***
// Register offsets, field positions, reset values and timing figures
// for the limit comparison and alarm block. Definitions only.
`ifndef TLA_CONSTS_VH
`define TLA_CONSTS_VH

// Read addresses
`define TLA_RD_STAT1       8'h02
`define TLA_RD_CFG1        8'h03
`define TLA_RD_RATE        8'h04
`define TLA_RD_LOC_HIGH    8'h05
`define TLA_RD_LOC_LOW     8'h06
`define TLA_RD_REM_HIGH_HB 8'h07
`define TLA_RD_REM_LOW_HB  8'h08
`define TLA_RD_STAT2       8'h23

// Write addresses
`define TLA_WR_CFG1        8'h09
`define TLA_WR_RATE        8'h0A
`define TLA_WR_LOC_HIGH    8'h0B
`define TLA_WR_LOC_LOW     8'h0C
`define TLA_WR_REM_HIGH_HB 8'h0D
`define TLA_WR_REM_LOW_HB  8'h0E

// Shared read/write addresses
`define TLA_RW_REM_HIGH_LB 8'h13
`define TLA_RW_REM_LOW_LB  8'h14
`define TLA_RW_REMA_CRIT   8'h19
`define TLA_RW_LOC_CRIT    8'h20
`define TLA_RW_HYST        8'h21
`define TLA_RW_REMB_CRIT   8'h31

// Configuration 1 fields
`define TLA_CFG_MASK_ALL   7
`define TLA_CFG_STANDBY    6
`define TLA_CFG_PIN_SEL    5
`define TLA_CFG_REM_SEL    3
`define TLA_CFG_MASK_REMA  1
`define TLA_CFG_MASK_REMB  0

// Reset values and highest rate code
`define TLA_RST_CFG1       8'h00
`define TLA_RST_RATE       4'h7
`define TLA_RST_HIGH       8'h55
`define TLA_RST_LOW        8'h00
`define TLA_RST_LB         3'h0
`define TLA_RST_CRIT       8'h55
`define TLA_RST_HYST       8'h0A
`define TLA_RATE_MAX       4'hA

// Timing: slowest conversion period at code 0, and clock rate
`define TLA_SLOW_PERIOD_MS 16000
`define TLA_CLK_KHZ        100000

`endif

// *** design/tla_sync.v ***
// Two flip-flop synchroniser for levels arriving from pins.
// Assumes the same clock, reset and clock enable as the alarm block.
`timescale 1ns/1ps
module tla_sync
#(
  parameter W = 2
)
(
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire         i_clk_en,
  // Data
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else if (i_clk_en)
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

// *** design/tla_chan.v ***
// One temperature channel: sticky high, low and open flags plus
// self-clearing critical and high-with-hysteresis alarm levels.
// Assumes the measurement and limits are stable registers of the caller.
`timescale 1ns/1ps
module tla_chan
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_clk_en,
  // Measurement and high/low limits 8.3 format, critical limit and hysteresis 8-bit integer
  input  wire [10:0] i_meas,
  input  wire        i_open,
  input  wire [10:0] i_high_lim,
  input  wire [10:0] i_low_lim,
  input  wire [7:0]  i_crit_lim,
  input  wire [7:0]  i_hyst,
  // Status register read strobe
  input  wire        i_rd_clr,
  // Flags
  output reg         o_high_flag,
  output reg         o_low_flag,
  output reg         o_open_flag,
  output reg         o_crit_flag,
  output reg         o_hot_flag
);

  wire       high_cond;
  wire       low_cond;
  wire       crit_cond;
  wire [8:0] crit_diff;
  wire [8:0] high_diff;
  wire [7:0] crit_rel;
  wire [7:0] high_rel;

  assign high_cond = i_meas > i_high_lim;
  assign low_cond  = i_meas <= i_low_lim;
  assign crit_cond = i_meas > {i_crit_lim, 3'h0};

  // Release thresholds saturate at zero rather than wrap
  assign crit_diff = {1'b0, i_crit_lim} - {1'b0, i_hyst};
  assign high_diff = {1'b0, i_high_lim[10:3]} - {1'b0, i_hyst};
  assign crit_rel  = crit_diff[8] ? 8'h00 : crit_diff[7:0];
  assign high_rel  = high_diff[8] ? 8'h00 : high_diff[7:0];

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_high_flag <= 1'b0;
      o_low_flag  <= 1'b0;
      o_open_flag <= 1'b0;
      o_crit_flag <= 1'b0;
      o_hot_flag  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Set wins over the read clear; cleared only once in limit
      o_high_flag <= high_cond | (o_high_flag & ~i_rd_clr);
      o_low_flag  <= low_cond | (o_low_flag & ~i_rd_clr);
      o_open_flag <= i_open | (o_open_flag & ~i_rd_clr);
      if (crit_cond)
        o_crit_flag <= 1'b1;
      else if (i_meas[10:3] < crit_rel)
        o_crit_flag <= 1'b0;
      if (high_cond)
        o_hot_flag <= 1'b1;
      else if (i_meas[10:3] < high_rel)
        o_hot_flag <= 1'b0;
    end
  end

endmodule

// *** verif/tla_sva.sv ***
// Port checker for the limit and alarm block.
// Assumes i_clk_en is held high and reads use the one-cycle strobe.
`timescale 1ns/1ps
module tla_sva
(
  // Clock, reset, register strobes
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_clk_en,
  input wire [7:0]  i_reg_addr,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire        i_adc_busy,
  input wire        i_meas_valid,
  // Observed outputs
  input wire [7:0]  o_reg_rdata,
  input wire        o_conv_start,
  input wire [3:0]  o_conv_rate,
  input wire        o_standby_select,
  input wire        o_critical_overtemp_n,
  input wire        o_shared_pin_n
);
  wire rd_ok = i_reg_rd & i_clk_en;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
////////////////////////////////////////
  chk_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=>
    o_reg_rdata == 8'h00 && o_critical_overtemp_n && o_shared_pin_n
    && !o_conv_start && o_conv_rate == 4'h7) else $error("outputs not idle after reset");
  chk_rdata_hold: assert property (!rd_ok |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  chk_rate_stable: assert property (!(i_reg_wr && i_reg_addr == 8'h0A)
    |=> $stable(o_conv_rate)) else $error("rate moved without a write");
  chk_rate_read: assert property (rd_ok && i_reg_addr == 8'h04
    |=> o_reg_rdata == {4'h0, o_conv_rate}) else $error("rate readback wrong");
  chk_busy_bit: assert property (rd_ok && i_reg_addr == 8'h02
    |=> o_reg_rdata[7] == $past(i_adc_busy)) else $error("converting bit wrong");
  chk_stat2_resv: assert property (rd_ok && i_reg_addr == 8'h23
    |=> o_reg_rdata[7:5] == 3'h0) else $error("reserved status bits set");
  chk_crit_cause: assert property ($fell(o_critical_overtemp_n)
    |-> $past(i_meas_valid, 3) || $past(i_reg_wr, 3)) else $error("critical pin fell alone");
  chk_conv_gap: assert property (o_conv_start |=> !o_conv_start [*8])
    else $error("conversion starts too close");
  chk_standby_quiet: assert property (o_standby_select && $past(o_standby_select)
    |-> !o_conv_start) else $error("conversion started in standby");
  cover property (!o_critical_overtemp_n);
  cover property (!o_shared_pin_n ##1 o_shared_pin_n);
  cover property (o_conv_start);
endmodule

bind tla_status_alarm tla_sva u_sva
(
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_adc_busy(i_adc_busy), .i_meas_valid(i_meas_valid), .o_reg_rdata(o_reg_rdata),
  .o_conv_start(o_conv_start), .o_conv_rate(o_conv_rate),
  .o_standby_select(o_standby_select),
  .o_critical_overtemp_n(o_critical_overtemp_n), .o_shared_pin_n(o_shared_pin_n)
);

// *** verif/tla_host.sv ***
// Host and converter stand-in for the alarm block.
// Assumes every strobe is sampled on the rising edge of i_clk.
`timescale 1ns/1ps
module tla_host
(
  // Clock
  input  wire        i_clk,
  // Register bus and alert service
  output reg  [7:0]  o_addr,
  output reg         o_wr,
  output reg  [7:0]  o_wdata,
  output reg         o_rd,
  input  wire [7:0]  i_rdata,
  output reg         o_ara,
  // Conversion results
  output reg         o_mv,
  output reg  [1:0]  o_chan,
  output reg  [10:0] o_val
);
  initial
  begin
    {o_addr, o_wr, o_wdata, o_rd, o_ara, o_mv, o_chan, o_val} = '0;
  end
////////////////////////////////////////
  // Reserved rate bits always go out as zero
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= (a == 8'h0A) ? {4'h0, v[3:0]} : v;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~v;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 v = i_rdata;
  endtask

  // Only issued once the flags were read back clean
  task ara;
    @(posedge i_clk);
    o_ara <= 1'b1;
    @(posedge i_clk);
    o_ara <= 1'b0;
  endtask

  // Results in the same binary scale as the limits
  task meas(input logic [1:0] c, input logic [10:0] v);
    @(posedge i_clk);
    o_chan <= c;
    o_val  <= v;
    o_mv   <= 1'b1;
    @(posedge i_clk);
    o_mv   <= 1'b0;
    o_val  <= ~v;
    @(posedge i_clk);
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the limit and alarm block.
// Assumes the host model issues all strobes; clock enable held high except while t_standby freezes one result.
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic        busy;
  logic        en;
  logic        open_a;
  logic        open_b;
  logic [7:0]  d;
  int          error_cnt;
  int          checked;
  wire  [7:0]  addr;
  wire  [7:0]  wdata;
  wire  [7:0]  rdata;
  wire  [10:0] val;
  wire  [1:0]  chan;
  wire  [3:0]  rate;
  wire         wr;
  wire         rd;
  wire         ara;
  wire         mv;
  wire         conv;
  wire         stby;
  wire         crit_n;
  wire         pin_n;

  tla_status_alarm #(.P_SLOW_CYCLES(31'd16384)) u_tla_status_alarm
  (
    .i_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_ara_read(ara), .i_adc_busy(busy), .i_meas_valid(mv), .i_meas_chan(chan),
    .i_meas_value(val), .i_remote_a_open(open_a), .i_remote_b_open(open_b),
    .o_conv_start(conv), .o_conv_rate(rate), .o_standby_select(stby),
    .o_critical_overtemp_n(crit_n), .o_shared_pin_n(pin_n)
  );
  tla_host u_host
  (
    .i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
    .i_rdata(rdata), .o_ara(ara), .o_mv(mv), .o_chan(chan), .o_val(val)
  );
////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task rc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask

  // Pins are levels, so a short settle is harmless
  task pc(input logic s, input logic e);
    repeat (3) @(posedge clk);
    #1 chk(s ? "shared_pin_n" : "crit_n", {7'h0, e}, {7'h0, s ? pin_n : crit_n});
  endtask

  task t_defaults;
    logic [63:0] a;
    logic [63:0] e;
    a = 64'h042105062019037F;
    e = 64'h070A550055550000;
    for (int i = 7; i >= 0; i--)
      rc(a[8*i +: 8], e[8*i +: 8]);
    rc(8'h02, 8'h28);
    rc(8'h23, 8'h09);
    pc(1'b1, 1'b0);
  endtask

  task t_alert;
    u_host.wr(8'h0B, 8'h40);
    u_host.wr(8'h0C, 8'h20);
    u_host.meas(2'd0, 11'h200);
    u_host.meas(2'd1, 11'h100);
    u_host.meas(2'd2, 11'h100);
    u_host.rd(8'h02, d);
    u_host.rd(8'h23, d);
    rc(8'h02, 8'h00);
    rc(8'h23, 8'h01);
    u_host.ara();
    pc(1'b1, 1'b1);
    rc(8'h23, 8'h00);
  endtask

  task t_cmp;
    u_host.meas(2'd0, 11'h208);
    rc(8'h02, 8'h40);
    pc(1'b1, 1'b0);
    u_host.meas(2'd0, 11'h100);
    rc(8'h02, 8'h60);
    rc(8'h02, 8'h20);
    u_host.meas(2'd0, 11'h180);
    rc(8'h02, 8'h20);
    rc(8'h02, 8'h00);
    u_host.ara();
    pc(1'b1, 1'b1);
  endtask

  task t_mask;
    u_host.wr(8'h09, 8'h80);
    u_host.meas(2'd0, 11'h208);
    pc(1'b1, 1'b1);
    rc(8'h23, 8'h00);
    u_host.meas(2'd0, 11'h180);
    rc(8'h02, 8'h40);
    u_host.wr(8'h09, 8'h02);
    u_host.meas(2'd1, 11'h000);
    pc(1'b1, 1'b1);
    rc(8'h02, 8'h08);
    u_host.meas(2'd1, 11'h100);
    u_host.rd(8'h02, d);
    u_host.wr(8'h09, 8'h00);
    pc(1'b1, 1'b1);
  endtask

  task t_crit;
    logic [7:0] a;
    logic [7:0] b;
    for (int c = 0; c < 3; c++)
    begin
      a = (c == 2) ? 8'h23 : 8'h02;
      b = (c == 0) ? 8'h01 : 8'h02;
      u_host.meas(c[1:0], 11'h2B0);
      pc(1'b0, 1'b0);
      u_host.rd(a, d);
      chk("crit_bit", b, d & b);
      u_host.meas(c[1:0], 11'h260);
      pc(1'b0, 1'b0);
      u_host.meas(c[1:0], 11'h250);
      pc(1'b0, 1'b1);
      u_host.rd(a, d);
      chk("crit_bit", 8'h00, d & b);
      u_host.meas(c[1:0], (c == 0) ? 11'h180 : 11'h100);
    end
    u_host.rd(8'h02, d);
    u_host.rd(8'h23, d);
    u_host.ara();
    pc(1'b1, 1'b1);
  endtask

  task t_second_overtemp_n;
    u_host.wr(8'h09, 8'h20);
    u_host.meas(2'd0, 11'h080);
    pc(1'b1, 1'b1);
    u_host.meas(2'd0, 11'h208);
    pc(1'b1, 1'b0);
    u_host.meas(2'd0, 11'h180);
    pc(1'b1, 1'b1);
    rc(8'h23, 8'h00);
    u_host.rd(8'h02, d);
    u_host.wr(8'h09, 8'h00);
    pc(1'b1, 1'b1);
  endtask

  task t_open;
    @(posedge clk);
    open_a <= 1'b1;
    open_b <= 1'b1;
    repeat (6) @(posedge clk);
    open_a <= 1'b0;
    open_b <= 1'b0;
    repeat (6) @(posedge clk);
    rc(8'h02, 8'h04);
    rc(8'h02, 8'h00);
    rc(8'h23, 8'h05);
    rc(8'h23, 8'h01);
    u_host.ara();
    pc(1'b1, 1'b1);
  endtask

  task t_rate;
    int n;
    for (int r = 7; r < 11; r += 3)
    begin
      u_host.wr(8'h0A, {4'hF, r[3:0]});
      rc(8'h04, {4'h0, r[3:0]});
      repeat (2)
      begin
        n = 0;
        do
        begin
          @(posedge clk);
          #1;
          n++;
        end
        while (conv !== 1'b1 && n < 400);
      end
      chk("conv_period", 8'(16384 >> r), n[7:0]);
    end
  endtask

  task t_standby;
    u_host.wr(8'h09, 8'h40);
    #1 chk("standby", 8'h01, {7'h0, stby});
    u_host.wr(8'h20, 8'h28);
    pc(1'b0, 1'b0);
    u_host.wr(8'h20, 8'h55);
    pc(1'b0, 1'b1);
    // Frozen block must ignore a result that would trip the high and critical limits
    @(posedge clk);
    en <= 1'b0;
    u_host.meas(2'd0, 11'h2B0);
    en <= 1'b1;
    pc(1'b0, 1'b1);
    @(posedge clk);
    busy <= 1'b1;
    rc(8'h02, 8'h80);
    busy <= 1'b0;
    u_host.wr(8'h09, 8'h00);
  endtask

  task end_sim;
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is several hundred cycles
  initial
  begin
    #300000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    rst    = 1'b1;
    busy   = 1'b0;
    en     = 1'b1;
    open_a = 1'b0;
    open_b = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_alert();
    t_cmp();
    t_mask();
    t_crit();
    t_second_overtemp_n();
    t_open();
    t_rate();
    t_standby();
    end_sim();
  end
endmodule
